// ==== rtl/digital_positioning_control.v ====
// photoelectric stop positioning controller with apb register file
//
// Summary of operation
// - pulse enable form: each positioning starts on an enable terminal edge
// - level enable form: positioning starts while enable terminal reads on
// - config bit 9 picks target from digital setting or fieldbus
// - config bit 10 keeps or clears encoder count on power loss
// - config bit 12 stores curve shape; other upper bits reserved
// - target is 16-bit low half joined with high half
// - speed source codes 0..6 pick digital, analog, fast pulse, fieldbus
// - digital speed in 0.1 percent of max, default 20.0, limit 100.0
// - speed rises at rate set by accel time, 0.01..300.00 s
// - speed falls at rate set by decel time, 0.01..300.00 s
// - destination held for hold time, default 0.100 s, max 60 s
// - completion output lasts signal hold time, default 0.200 s
// - mode value 0x0021 selects photoelectric stop positioning
// - input eight function code 43 makes it the stop trigger
// - travel is target times gear ratio; decel time sets stop ramp
// - too fast or too short travel gives direct deceleration
// - photoelectric stop works only under closed loop vector control
// - completion form bit: timed pulse or continuously valid
// - completion after deviation stays inside zone beyond detect time
// - hold after completion; cyclic enable resumes running to next trigger
//
// The APB register port and the register offsets were decided locally.
`include "positioning_map.vh"
`timescale 1ns/10ps
`default_nettype none
module digital_positioning_control #(
	parameter ADDR_W = 8,
	parameter TICK_CYCLES = `TICK_CYC,
	parameter DIST_SHIFT = `DIST_SHIFT_DEF
) (
	input wire clk_sys,
	input wire rstn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output wire pslverr,
	input wire encStep,
	input wire encDir,
	input wire digitalInputEight,
	input wire posEnableIn,
	input wire cyclicEnableIn,
	input wire closedLoopIn,
	input wire powerLossIn,
	input wire [15:0] analogInputOne,
	input wire [15:0] analogInputTwo,
	input wire [15:0] analogInputThree,
	input wire [15:0] fastPulseInputOne,
	input wire [15:0] fastPulseInputTwo,
	input wire [15:0] busSpeed,
	input wire [31:0] busTarget,
	output wire [15:0] speedCmd,
	output reg posDone,
	output reg holdActive,
	output reg directDecel,
	output reg positioning
);
	localparam S_IDLE = 3'h0;
	localparam S_RUN = 3'h1;
	localparam S_DECEL = 3'h2;
	localparam S_SETTLE = 3'h3;
	localparam S_HOLD = 3'h4;
	localparam S_DONE = 3'h5;
	localparam NPIN = 7;

	reg [15:0] config_reg;
	reg [15:0] tgtLow_reg;
	reg [15:0] tgtHigh_reg;
	reg [15:0] spdSrc_reg;
	reg [15:0] spdDig_reg;
	reg [15:0] accTime_reg;
	reg [15:0] decTime_reg;
	reg [15:0] destHold_reg;
	reg [15:0] doneHold_reg;
	reg [15:0] modeSel_reg;
	reg [15:0] inEightFn_reg;
	reg [15:0] gearNum_reg;
	reg [15:0] gearDen_reg;
	reg [15:0] zone_reg;
	reg [15:0] detect_reg;
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [31:0] encCount_reg;
	reg [31:0] ref_reg;
	reg [31:0] scaled_reg;
	reg [31:0] tickCnt_reg;
	reg [19:0] phaseCnt_reg;
	reg [19:0] doneCnt_reg;
	reg [NPIN-1:0] syncA_reg;
	reg [NPIN-1:0] syncB_reg;
	reg [NPIN-1:0] prev_reg;
	reg [15:0] spdSel;
	reg [31:0] rdData;
	reg rdHit;

	// pins pass two flip-flops before use
	wire [NPIN-1:0] pinRaw = {powerLossIn, closedLoopIn, cyclicEnableIn, posEnableIn,
		digitalInputEight, encDir, encStep};
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi = gi + 1) begin : pinSync
			always @(posedge clk_sys) begin
				if (!rstn) begin
					syncA_reg[gi] <= 1'h0;
					syncB_reg[gi] <= 1'h0;
					prev_reg[gi] <= 1'h0;
				end else begin
					syncA_reg[gi] <= pinRaw[gi];
					syncB_reg[gi] <= syncA_reg[gi];
					prev_reg[gi] <= syncB_reg[gi];
				end
			end
		end
	endgenerate
	wire stepRise = syncB_reg[0] & ~prev_reg[0];
	wire dirFwd = syncB_reg[1];
	wire photoRise = syncB_reg[2] & ~prev_reg[2];
	wire enableLevel = syncB_reg[3];
	wire enableRise = syncB_reg[3] & ~prev_reg[3];
	wire cyclicRise = syncB_reg[4] & ~prev_reg[4];
	wire closedLoop = syncB_reg[5];
	wire powerLoss = syncB_reg[6];

	// apb access decode
	wire wrEn = psel & penable & pwrite;
	wire [7:0] addrLow = paddr[7:0];
	wire wordAddr = paddr[1:0] == 2'h0;
	assign pready = 1'h1;
	assign pslverr = psel & penable & ~rdHit;

	// photo stop is armed only by mode, input function and closed loop
	wire armed = (modeSel_reg == `MODE_PHOTO_STOP)
		&& (inEightFn_reg == `FN_PHOTO_STOP)
		&& closedLoop;
	wire startReq = config_reg[`CFG_ENABLE_FORM] ? enableLevel
		: enableRise;
	wire cycResume = cyclicRise & ~config_reg[`CFG_CYCLIC_AUTO];

	// target assembly and gear scaling
	wire [31:0] digTarget = {tgtHigh_reg, tgtLow_reg};
	wire [31:0] target = config_reg[`CFG_POS_SOURCE] ? busTarget : digTarget;
	wire [47:0] gearProd = target * gearNum_reg;
	wire [47:0] gearQuot = gearProd / {32'h0000_0000, gearDen_reg};
	wire [31:0] scaledNow = gearQuot[31:0];

	// remaining travel from referenced encoder count
	wire [31:0] travelled = encCount_reg - ref_reg;
	wire [31:0] remaining = scaled_reg - travelled;
	wire remainingDone = remaining[31] || (remaining == 32'h0000_0000);
	wire [31:0] deviation = remaining[31] ? 32'h0000_0000 - remaining : remaining;
	wire inZone = deviation < {16'h0000, zone_reg};

	// stopping distance at the present speed over the decel ramp
	wire [31:0] stopProd = speedCmd * decTime_reg;
	wire [31:0] stopDist = stopProd >> DIST_SHIFT;
	wire [31:0] trigStopDist = spdSel * decTime_reg;

	// speed source selection
	always @* begin
		case (spdSrc_reg[2:0])
			`SRC_DIGITAL: spdSel = spdDig_reg;
			`SRC_ANALOG_ONE: spdSel = analogInputOne;
			`SRC_ANALOG_TWO: spdSel = analogInputTwo;
			`SRC_ANALOG_THREE: spdSel = analogInputThree;
			`SRC_FAST_ONE: spdSel = fastPulseInputOne;
			`SRC_FAST_TWO: spdSel = fastPulseInputTwo;
			`SRC_BUS: spdSel = busSpeed;
			default: spdSel = spdDig_reg;
		endcase
	end
	wire [15:0] spdSet = (spdSel > `SPD_MAX) ? `SPD_MAX : spdSel;

	// ramp target: set speed while running, zero once inside stop distance
	wire rampToZero = (state_reg == S_DECEL) && (remaining[31] || remaining <= stopDist);
	wire running = (state_reg == S_RUN) || (state_reg == S_DECEL);
	wire [15:0] rampTarget = (running && !rampToZero) ? spdSet : 16'h0000;
	wire jump = (state_reg == S_DECEL) && directDecel;

	speed_ramp #(
		.STEP_CYCLES(`RAMP_STEP_CYC)
	) ramp (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.targetSpeed(rampTarget),
		.accTime(accTime_reg),
		.decTime(decTime_reg),
		.jumpToZero(jump),
		.speed_reg(speedCmd)
	);

	// 0.1 ms time base for hold and detect timers
	wire tick = tickCnt_reg == TICK_CYCLES - 1;
	always @(posedge clk_sys) begin
		if (!rstn) begin
			tickCnt_reg <= 32'h0000_0000;
		end else begin
			tickCnt_reg <= tick ? 32'h0000_0000 : tickCnt_reg + 32'h0000_0001;
		end
	end
	wire [19:0] destTicks = destHold_reg * `TICKS_PER_MS;
	wire [19:0] doneTicks = doneHold_reg * `TICKS_PER_MS;
	wire detectMet = inZone && (phaseCnt_reg >= {4'h0, detect_reg});
	wire holdMet = phaseCnt_reg >= destTicks;

	// sequencing of run, stop ramp, settle, hold and done
	always @* begin
		state_next = state_reg;
		case (state_reg)
			S_IDLE: begin
				if (armed && startReq) begin
					state_next = S_RUN;
				end
			end
			S_RUN: begin
				if (!armed) begin
					state_next = S_IDLE;
				end else if (photoRise) begin
					state_next = S_DECEL;
				end
			end
			S_DECEL: begin
				if (speedCmd == 16'h0000 || remainingDone) begin
					state_next = S_SETTLE;
				end
			end
			S_SETTLE: begin
				if (detectMet) begin
					state_next = S_HOLD;
				end
			end
			S_HOLD: begin
				if (holdMet) begin
					state_next = S_DONE;
				end
			end
			S_DONE: begin
				if (!armed) begin
					state_next = S_IDLE;
				end else if (startReq || cycResume) begin
					state_next = S_RUN;
				end
			end
			default: state_next = S_IDLE;
		endcase
	end

	// state, trigger reference and phase timers
	always @(posedge clk_sys) begin
		if (!rstn) begin
			state_reg <= S_IDLE;
			ref_reg <= 32'h0000_0000;
			scaled_reg <= 32'h0000_0000;
			phaseCnt_reg <= 20'h0_0000;
			directDecel <= 1'h0;
		end else begin
			state_reg <= state_next;
			if (state_reg == S_RUN && state_next == S_DECEL) begin
				ref_reg <= encCount_reg;
				scaled_reg <= scaledNow;
				directDecel <= (trigStopDist >> DIST_SHIFT) > scaledNow;
			end else if (state_next == S_RUN) begin
				directDecel <= 1'h0;
			end
			if (state_next != state_reg) begin
				phaseCnt_reg <= 20'h0_0000;
			end else if (state_reg == S_SETTLE && !inZone) begin
				phaseCnt_reg <= 20'h0_0000;
			end else if (tick && phaseCnt_reg != 20'hF_FFFF) begin
				phaseCnt_reg <= phaseCnt_reg + 20'h0_0001;
			end
		end
	end

	// completion output, pulse or continuous form
	always @(posedge clk_sys) begin
		if (!rstn) begin
			posDone <= 1'h0;
			doneCnt_reg <= 20'h0_0000;
		end else if (state_reg == S_SETTLE && detectMet) begin
			posDone <= 1'h1;
			doneCnt_reg <= 20'h0_0000;
		end else if (state_next == S_RUN || state_next == S_IDLE) begin
			posDone <= 1'h0;
		end else if (posDone && !config_reg[`CFG_DONE_FORM]) begin
			if (doneCnt_reg >= doneTicks) begin
				posDone <= 1'h0;
			end else if (tick) begin
				doneCnt_reg <= doneCnt_reg + 20'h0_0001;
			end
		end
	end

	// status flags
	always @(posedge clk_sys) begin
		if (!rstn) begin
			holdActive <= 1'h0;
			positioning <= 1'h0;
		end else begin
			holdActive <= state_next >= S_SETTLE;
			positioning <= state_next == S_DECEL;
		end
	end

	// signed encoder count with optional power loss retention
	always @(posedge clk_sys) begin
		if (!rstn) begin
			encCount_reg <= 32'h0000_0000;
		end else if (powerLoss && !config_reg[`CFG_RETAIN]) begin
			encCount_reg <= 32'h0000_0000;
		end else if (stepRise) begin
			encCount_reg <= dirFwd ? encCount_reg + 32'h0000_0001
				: encCount_reg - 32'h0000_0001;
		end
	end

	// register writes with range limiting
	always @(posedge clk_sys) begin
		if (!rstn) begin
			config_reg <= `RST_CONFIG;
			tgtLow_reg <= 16'h0000;
			tgtHigh_reg <= 16'h0000;
			spdSrc_reg <= 16'h0000;
			spdDig_reg <= `RST_SPD_DIG;
			accTime_reg <= `RST_RAMP_TIME;
			decTime_reg <= `RST_RAMP_TIME;
			destHold_reg <= `RST_DEST_HOLD;
			doneHold_reg <= `RST_DONE_HOLD;
			modeSel_reg <= 16'h0000;
			inEightFn_reg <= 16'h0000;
			gearNum_reg <= `RST_GEAR_NUM;
			gearDen_reg <= `RST_GEAR_DEN;
			zone_reg <= `RST_ZONE;
			detect_reg <= `RST_DETECT;
		end else if (wrEn && wordAddr) begin
			case (addrLow)
				`OFS_CONFIG: config_reg <= pwdata[15:0] & `CFG_WRITE_MASK;
				`OFS_TGT_LOW: tgtLow_reg <= pwdata[15:0];
				`OFS_TGT_HIGH: tgtHigh_reg <= pwdata[15:0];
				`OFS_SPD_SRC: begin
					if (pwdata[15:0] <= `SRC_MAX) begin
						spdSrc_reg <= pwdata[15:0];
					end
				end
				`OFS_SPD_DIG: spdDig_reg <= (pwdata[15:0] > `SPD_MAX) ? `SPD_MAX
					: pwdata[15:0];
				`OFS_ACC_TIME: accTime_reg <= (pwdata[15:0] > `RAMP_MAX) ? `RAMP_MAX
					: (pwdata[15:0] < `RAMP_MIN) ? `RAMP_MIN : pwdata[15:0];
				`OFS_DEC_TIME: decTime_reg <= (pwdata[15:0] > `RAMP_MAX) ? `RAMP_MAX
					: (pwdata[15:0] < `RAMP_MIN) ? `RAMP_MIN : pwdata[15:0];
				`OFS_DEST_HOLD: destHold_reg <= (pwdata[15:0] > `HOLD_MAX) ? `HOLD_MAX
					: pwdata[15:0];
				`OFS_DONE_HOLD: doneHold_reg <= (pwdata[15:0] > `HOLD_MAX) ? `HOLD_MAX
					: pwdata[15:0];
				`OFS_MODE_SEL: modeSel_reg <= pwdata[15:0];
				`OFS_IN8_FUNC: inEightFn_reg <= pwdata[15:0];
				`OFS_GEAR_NUM: begin
					if (pwdata[15:0] != 16'h0000) begin
						gearNum_reg <= pwdata[15:0];
					end
				end
				`OFS_GEAR_DEN: begin
					if (pwdata[15:0] != 16'h0000) begin
						gearDen_reg <= pwdata[15:0]; // no divide by zero
					end
				end
				`OFS_ZONE: zone_reg <= (pwdata[15:0] > `ZONE_MAX) ? `ZONE_MAX
					: pwdata[15:0];
				`OFS_DETECT: detect_reg <= (pwdata[15:0] > `DETECT_MAX) ? `DETECT_MAX
					: pwdata[15:0];
				default: ;
			endcase
		end
	end

	// read mux and address hit
	always @* begin
		rdHit = wordAddr;
		rdData = 32'h0000_0000;
		case (addrLow)
			`OFS_CONFIG: rdData = {16'h0000, config_reg};
			`OFS_TGT_LOW: rdData = {16'h0000, tgtLow_reg};
			`OFS_TGT_HIGH: rdData = {16'h0000, tgtHigh_reg};
			`OFS_SPD_SRC: rdData = {16'h0000, spdSrc_reg};
			`OFS_SPD_DIG: rdData = {16'h0000, spdDig_reg};
			`OFS_ACC_TIME: rdData = {16'h0000, accTime_reg};
			`OFS_DEC_TIME: rdData = {16'h0000, decTime_reg};
			`OFS_DEST_HOLD: rdData = {16'h0000, destHold_reg};
			`OFS_DONE_HOLD: rdData = {16'h0000, doneHold_reg};
			`OFS_MODE_SEL: rdData = {16'h0000, modeSel_reg};
			`OFS_IN8_FUNC: rdData = {16'h0000, inEightFn_reg};
			`OFS_GEAR_NUM: rdData = {16'h0000, gearNum_reg};
			`OFS_GEAR_DEN: rdData = {16'h0000, gearDen_reg};
			`OFS_ZONE: rdData = {16'h0000, zone_reg};
			`OFS_DETECT: rdData = {16'h0000, detect_reg};
			`OFS_STATUS: rdData = {speedCmd, 8'h00, positioning, directDecel,
				holdActive, posDone, armed, state_reg};
			`OFS_ENC_COUNT: rdData = encCount_reg;
			default: rdHit = 1'h0;
		endcase
		if (ADDR_W > 8 && (paddr >> 8) != 0) begin
			rdHit = 1'h0;
		end
	end

	// read data registered in the setup cycle
	always @(posedge clk_sys) begin
		if (!rstn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rdHit ? rdData : 32'h0000_0000;
		end
	end
endmodule
`default_nettype wire

// ==== rtl/positioning_map.vh ====
// register map, field positions, reset values and timing for positioning control
`ifndef POSITIONING_MAP_VH
`define POSITIONING_MAP_VH
// register byte offsets
`define OFS_CONFIG 8'h00
`define OFS_TGT_LOW 8'h04
`define OFS_TGT_HIGH 8'h08
`define OFS_SPD_SRC 8'h0C
`define OFS_SPD_DIG 8'h10
`define OFS_ACC_TIME 8'h14
`define OFS_DEC_TIME 8'h18
`define OFS_DEST_HOLD 8'h1C
`define OFS_DONE_HOLD 8'h20
`define OFS_MODE_SEL 8'h24
`define OFS_IN8_FUNC 8'h28
`define OFS_GEAR_NUM 8'h2C
`define OFS_GEAR_DEN 8'h30
`define OFS_ZONE 8'h34
`define OFS_DETECT 8'h38
`define OFS_STATUS 8'h3C
`define OFS_ENC_COUNT 8'h40
// configuration word fields
`define CFG_CYCLIC_AUTO 1
`define CFG_DONE_FORM 6
`define CFG_ENABLE_FORM 8
`define CFG_POS_SOURCE 9
`define CFG_RETAIN 10
`define CFG_CURVE 12
`define CFG_WRITE_MASK 16'h17FF
// reset values
`define RST_CONFIG 16'h0000
`define RST_SPD_DIG 16'h00C8
`define RST_RAMP_TIME 16'h012C
`define RST_DEST_HOLD 16'h0064
`define RST_DONE_HOLD 16'h00C8
`define RST_GEAR_NUM 16'h03E8
`define RST_GEAR_DEN 16'h0001
`define RST_ZONE 16'h000A
`define RST_DETECT 16'h0064
// value limits
`define SPD_MAX 16'h03E8
`define RAMP_MIN 16'h0001
`define RAMP_MAX 16'h7530
`define HOLD_MAX 16'hEA60
`define ZONE_MAX 16'h03E8
`define DETECT_MAX 16'h2710
`define SRC_MAX 16'h0006
// command codes
`define MODE_PHOTO_STOP 16'h0021
`define FN_PHOTO_STOP 16'h002B
// speed source codes
`define SRC_DIGITAL 3'h0
`define SRC_ANALOG_ONE 3'h1
`define SRC_ANALOG_TWO 3'h2
`define SRC_ANALOG_THREE 3'h3
`define SRC_FAST_ONE 3'h4
`define SRC_FAST_TWO 3'h5
`define SRC_BUS 3'h6
// timing: one speed step of 0.1 percent per 0.01 s of ramp time
`define CLK_PERIOD_NS 10
`define RAMP_STEP_NS 10000
`define RAMP_STEP_CYC (`RAMP_STEP_NS / `CLK_PERIOD_NS)
`define TICK_NS 100000
`define TICK_CYC (`TICK_NS / `CLK_PERIOD_NS)
`define TICKS_PER_MS 20'h0000A
`define DIST_SHIFT_DEF 8
`endif

// ==== rtl/speed_ramp.v ====
// linear speed ramp with separate up and down rates
`include "positioning_map.vh"
`timescale 1ns/10ps
`default_nettype none
module speed_ramp #(
	parameter STEP_CYCLES = `RAMP_STEP_CYC
) (
	input wire clk_sys,
	input wire rstn,
	input wire [15:0] targetSpeed,
	input wire [15:0] accTime,
	input wire [15:0] decTime,
	input wire jumpToZero,
	output reg [15:0] speed_reg
);
	reg [15:0] unitCnt_reg;
	reg [15:0] timeCnt_reg;
	wire goUp = targetSpeed > speed_reg;
	wire goDown = targetSpeed < speed_reg;
	wire [15:0] rate = goUp ? accTime : decTime;
	wire unitDone = unitCnt_reg == STEP_CYCLES - 1;
	wire stepNow = unitDone && (timeCnt_reg + 16'h0001 >= rate);

	// one 0.1 percent step per ramp time in 0.01 s units
	always @(posedge clk_sys) begin
		if (!rstn) begin
			speed_reg <= 16'h0000;
			unitCnt_reg <= 16'h0000;
			timeCnt_reg <= 16'h0000;
		end else if (jumpToZero) begin
			speed_reg <= 16'h0000; // direct stop, no ramp
			unitCnt_reg <= 16'h0000;
			timeCnt_reg <= 16'h0000;
		end else if (!goUp && !goDown) begin
			unitCnt_reg <= 16'h0000;
			timeCnt_reg <= 16'h0000;
		end else begin
			unitCnt_reg <= unitDone ? 16'h0000 : unitCnt_reg + 16'h0001;
			if (stepNow) begin
				timeCnt_reg <= 16'h0000;
				speed_reg <= goUp ? speed_reg + 16'h0001 : speed_reg - 16'h0001;
			end else if (unitDone) begin
				timeCnt_reg <= timeCnt_reg + 16'h0001;
			end
		end
	end
endmodule
`default_nettype wire

// ==== tb/positioning_checker.sv ====
// port-level checks for the positioning controller
`timescale 1ns/10ps
`default_nettype none
module positioning_checker #(
	parameter ADDR_W = 8
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic digitalInputEight,
	input wire logic [15:0] speedCmd,
	input wire logic posDone,
	input wire logic holdActive,
	input wire logic directDecel,
	input wire logic positioning
);
	logic [15:0] prevSpd;
	logic [15:0] since;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// cycles since the speed command last moved
	always @(posedge clk_sys) begin
		prevSpd <= speedCmd;
		if (!rstn || speedCmd != prevSpd) begin
			since <= 16'h0000;
		end else if (since != 16'hFFFF) begin
			since <= since + 16'h0001;
		end
	end
	ready_always_a: assert property (psel && penable |-> pready)
		else $error("pready low in access");
	bad_addr_a: assert property (psel && penable && !pwrite &&
		(paddr > 8'h40 || paddr[1:0] != 2'h0) |-> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped read not refused");
	good_addr_a: assert property (psel && penable && paddr <= 8'h40 && paddr[1:0] == 2'h0
		|-> !pslverr) else $error("mapped access refused");
	ramp_step_a: assert property ($changed(speedCmd) && !directDecel |->
		speedCmd == $past(speedCmd) + 16'h0001 || $past(speedCmd) == speedCmd + 16'h0001)
		else $error("speed jumped");
	ramp_pace_a: assert property ($changed(speedCmd) && !directDecel |->
		since >= 16'h03E6) else $error("speed step too early");
	photo_start_a: assert property ($rose(positioning) |->
		$past(digitalInputEight, 3)) else $error("stop ramp without trigger");
	done_in_hold_a: assert property (posDone |-> holdActive)
		else $error("done outside hold");
	state_excl_a: assert property (positioning |-> !holdActive && !posDone)
		else $error("stop ramp overlaps hold");
	direct_zero_a: assert property (directDecel && positioning |->
		##[0:3] speedCmd == 16'h0000) else $error("direct stop too slow");
	reset_quiet_a: assert property ($rose(rstn) |-> speedCmd == 16'h0000 && !posDone
		&& !positioning) else $error("outputs not cleared by reset");
	cover property ($rose(positioning));
	cover property ($rose(posDone));
	cover property ($rose(directDecel));
endmodule
bind digital_positioning_control positioning_checker #(.ADDR_W(ADDR_W)) watch (.clk_sys,
	.rstn, .psel, .penable, .pwrite, .paddr, .pready, .prdata, .pslverr,
	.digitalInputEight, .speedCmd, .posDone, .holdActive, .directDecel, .positioning);
`default_nettype wire

// ==== tb/far_side_model.sv ====
// encoder and photoelectric switch seen by the controller
`timescale 1ns/10ps
`default_nettype none
module far_side_model (
	input wire logic clk_sys,
	input wire logic [15:0] speedCmd,
	input wire logic fire,
	output logic encStep,
	output logic encDir,
	output logic photo
);
	bit [15:0] acc = 16'h0000; // two-state, so an unknown speed before reset cannot stick
	int hi = 0;
	initial begin
		encStep = 1'b0;
		encDir = 1'b1;
		photo = 1'b0;
	end
	// encoder pulse rate follows the speed command
	always @(posedge clk_sys) begin
		if (acc + speedCmd >= 16'h07D0) begin
			acc <= acc + speedCmd - 16'h07D0;
			encStep <= 1'b1;
		end else begin
			acc <= acc + speedCmd;
			encStep <= 1'b0;
		end
	end
	// switch pulse on input eight, eight cycles wide
	always @(posedge clk_sys) begin
		hi <= fire ? 8 : (hi > 0 ? hi - 1 : 0);
		photo <= fire || hi > 1;
	end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the positioning controller
`include "positioning_map.vh"
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic posEnableIn = 1'b0;
	logic cyclicEnableIn = 1'b0;
	logic closedLoopIn = 1'b1;
	logic powerLossIn = 1'b0;
	logic fire = 1'b0;
	logic [15:0] analogInputOne, analogInputTwo, analogInputThree, busSpeed;
	logic [15:0] fastPulseInputOne, fastPulseInputTwo, speedCmd;
	logic [31:0] busTarget, prdata, rd, d;
	logic pready, pslverr, encStep, encDir, digitalInputEight, err;
	logic posDone, holdActive, directDecel, positioning;
	logic [15:0] sh [0:14];
	int errors = 0;
	int checked = 0;
	int cycles = 0;
	int n;
	int i;
	digital_positioning_control #(.TICK_CYCLES(10)) DUT (.*);
	far_side_model FAR (.clk_sys(clk_sys), .speedCmd(speedCmd), .fire(fire),
		.encStep(encStep), .encDir(encDir), .photo(digitalInputEight));
	always #5 clk_sys = ~clk_sys;
	// run length ceiling
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 60000) begin
			errors++;
			conclude();
		end
	end
	task conclude;
		if (errors == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			errors++;
			$display("Error %0t: got %h want %h", $time, g, e);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		apb(1'b1, a, v);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, e);
	endtask
	task readAll;
		for (i = 0; i < 15; i++) if (i != 10) rdc(8'(i * 4), {16'h0000, sh[i]});
	endtask
	task trig;
		@(posedge clk_sys);
		fire <= 1'b1;
		@(posedge clk_sys);
		fire <= 1'b0;
	endtask
	function logic [15:0] rstOf(input int k);
		case (k)
			4: rstOf = `RST_SPD_DIG;
			5, 6: rstOf = `RST_RAMP_TIME;
			7: rstOf = `RST_DEST_HOLD;
			8: rstOf = `RST_DONE_HOLD;
			11: rstOf = `RST_GEAR_NUM;
			12: rstOf = `RST_GEAR_DEN;
			13: rstOf = `RST_ZONE;
			14: rstOf = `RST_DETECT;
			default: rstOf = 16'h0000;
		endcase
	endfunction
	// stored value after a write, with the limits applied
	function logic [15:0] expOf(input int k, input logic [15:0] v, input logic [15:0] o);
		case (k)
			0: expOf = v & 16'h17FF;
			3: expOf = v > 16'h0006 ? o : v;
			4: expOf = v > 16'h03E8 ? 16'h03E8 : v;
			5, 6: expOf = v < 16'h0001 ? 16'h0001 : (v > 16'h7530 ? 16'h7530 : v);
			7, 8: expOf = v > 16'hEA60 ? 16'hEA60 : v;
			11, 12: expOf = v == 16'h0000 ? o : v;
			13: expOf = v > 16'h03E8 ? 16'h03E8 : v;
			14: expOf = v > 16'h2710 ? 16'h2710 : v;
			default: expOf = v;
		endcase
	endfunction
	task doReset;
		rstn <= 1'b0;
		repeat (10) @(posedge clk_sys);
		rstn <= 1'b1;
		for (i = 0; i < 15; i++) sh[i] = rstOf(i);
	endtask
	initial begin
		void'($urandom(32'hc1f7));
		{analogInputTwo, analogInputThree, fastPulseInputOne, fastPulseInputTwo} = {$urandom, $urandom};
		busSpeed = 16'($urandom);
		busTarget = $urandom;
		analogInputOne = 16'h0000;
		doReset();
		readAll();
		// refused places read zero with an error
		for (n = 0; n < 2; n++) begin
			apb(1'b0, n ? 8'h44 : 8'h06, 32'h0000_0000);
			chk(rd, 32'h0000_0000);
			chk({31'h0, err}, 32'h0000_0001);
		end
		// random writes, corners mixed in
		for (n = 0; n < 40; n++) begin
			i = $urandom % 15;
			d = (n % 3 == 0) ? ((n % 2) ? 32'h0000_FFFF : 32'h0000_0000) : $urandom % 65536;
			wr(8'(i * 4), d);
			sh[i] = expOf(i, d[15:0], sh[i]);
		end
		readAll();
		// short photoelectric stop run
		doReset();
		wr(`OFS_IN8_FUNC, `FN_PHOTO_STOP);
		wr(`OFS_GEAR_NUM, 32'h0000_0001);
		wr(`OFS_SPD_DIG, 32'h0000_0005);
		wr(`OFS_ACC_TIME, 32'h0000_0001);
		wr(`OFS_DEC_TIME, 32'h0000_0001);
		wr(`OFS_DEST_HOLD, 32'h0000_0001);
		wr(`OFS_DONE_HOLD, 32'h0000_0002);
		wr(`OFS_TGT_LOW, 32'h0000_0008);
		posEnableIn <= 1'b1;
		repeat (2000) @(posedge clk_sys);
		chk(speedCmd, 32'h0000_0000);
		posEnableIn <= 1'b0;
		wr(`OFS_MODE_SEL, `MODE_PHOTO_STOP);
		posEnableIn <= 1'b1;
		for (n = 0; n < 9000 && speedCmd !== 16'h0005; n++) @(posedge clk_sys);
		chk(speedCmd, 32'h0000_0005);
		trig();
		for (n = 0; n < 25000 && posDone !== 1'b1; n++) @(posedge clk_sys);
		chk({31'h0, posDone}, 32'h0000_0001);
		for (n = 0; n < 1000 && posDone === 1'b1; n++) @(posedge clk_sys);
		// 20 ticks of 10 cycles, less up to one tick of time base phase
		chk({31'h0, n >= 191 && n <= 201}, 32'h0000_0001);
		// stop ramp may still run after completion; then it must stay stopped
		for (n = 0; n < 6000 && speedCmd !== 16'h0000; n++) @(posedge clk_sys);
		repeat (500) @(posedge clk_sys);
		chk(speedCmd, 32'h0000_0000);
		powerLossIn <= 1'b1;
		repeat (5) @(posedge clk_sys);
		powerLossIn <= 1'b0;
		rdc(`OFS_ENC_COUNT, 32'h0000_0000);
		// level form restart from an analog speed, completion held continuously
		wr(`OFS_SPD_SRC, 32'h0000_0001);
		analogInputOne <= 16'h0006;
		wr(`OFS_CONFIG, 32'h0000_0140);
		for (n = 0; n < 9000 && speedCmd !== 16'h0006; n++) @(posedge clk_sys);
		chk(speedCmd, 32'h0000_0006);
		// travel too short for the ramp
		wr(`OFS_DEC_TIME, `RAMP_MAX);
		wr(`OFS_TGT_LOW, 32'h0000_0000);
		trig();
		for (n = 0; n < 100 && directDecel !== 1'b1; n++) @(posedge clk_sys);
		chk({31'h0, directDecel}, 32'h0000_0001);
		repeat (5) @(posedge clk_sys);
		chk(speedCmd, 32'h0000_0000);
		// level low so the done state holds, then a cyclic pulse resumes
		posEnableIn <= 1'b0;
		for (n = 0; n < 25000 && posDone !== 1'b1; n++) @(posedge clk_sys);
		repeat (400) @(posedge clk_sys);
		chk({31'h0, posDone}, 32'h0000_0001);
		cyclicEnableIn <= 1'b1;
		repeat (10) @(posedge clk_sys);
		chk({30'h0, posDone, holdActive}, 32'h0000_0000);
		conclude();
	end
endmodule
`default_nettype wire
